// *** ucm_pkg.sv ***
// Constants and types for the USB charge mode selector
// Function
// - Enable high, select code 000: device off, output kept discharged.
// - Code 110 selects SDP; code 111 selects CDP with charging detection.
// - Code 010 selects SDP with remote wakeup for all devices.
// - Code 011: CDP low-speed wakeup; moves to DCP auto on FS/HS attach or detach.
// - Code 001 selects DCP auto-detect, charging detection, no remote wakeup.
// - Code 101 forced divider, code 100 forced BC1.2 DCP, both detect charging.
// - Auto-detect operation always starts in divider mode.
// - Auto-detect: on charging negotiation, discharge pulse then BC1.2 DCP.
// - Auto-detect: after BC1.2 device detach, back to divider after 10 s.
// - Codes x10 or 111 to/from 011 keep data switch on, no pulse.
// - Every other code change, save 110 to/from 010 and changes to 000, gives a 350 ms output discharge pulse.
// - Enable low: select ignored, output permanently discharged.
// - Charging modes: assert active-low charging flag above 20 mA threshold.
// - Charging flag released after 5 s below the threshold, or at once outside charging modes or during a discharge pulse.
// - CDP: flag asserted only if handshake finished before threshold crossing.
// - Enable low: switches and profiles off, flags released to high impedance.
package ucm_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_HZ         = 50_000_000;
  localparam int TICK_US        = 1000;
  localparam int TICK_CYCLES    = CLK_HZ / 1_000_000 * TICK_US;
  localparam int DISCH_MS       = 350;
  localparam int DCP_TIMEOUT_MS = 10_000;
  localparam int CHG_OFF_MS     = 5_000;
  localparam int STABLE_CYCLES  = 16;
  localparam int CNT_W          = 16;

  // ==========================================================================
  // Select codes {bit1, bit2, bit3}
  localparam logic [2:0] CODE_OFF       = 3'h0;
  localparam logic [2:0] CODE_DCP_AUTO  = 3'h1;
  localparam logic [2:0] CODE_SDP_RW    = 3'h2;
  localparam logic [2:0] CODE_CDP_RW    = 3'h3;
  localparam logic [2:0] CODE_FORCE_BC  = 3'h4;
  localparam logic [2:0] CODE_FORCE_DIV = 3'h5;
  localparam logic [2:0] CODE_SDP       = 3'h6;
  localparam logic [2:0] CODE_CDP       = 3'h7;

  // ==========================================================================
  // Register map
  localparam int          ADDR_W    = 8;
  localparam logic [7:0]  ADDR_STAT = 8'h00;
  localparam logic [7:0]  ADDR_MASK = 8'h04;
  localparam logic [7:0]  ADDR_MODE = 8'h08;
  localparam int          STAT_W    = 6;
  localparam logic [5:0]  MASK_RST  = 6'h00;
  localparam int ST_CODE   = 0;
  localparam int ST_DISCH  = 1;
  localparam int ST_TO_BC  = 2;
  localparam int ST_TO_DIV = 3;
  localparam int ST_CHG_ON = 4;
  localparam int ST_CHG_OFF = 5;
  // MODE register fields
  localparam int MD_PROF  = 0;
  localparam int MD_CODE  = 4;
  localparam int MD_DISCH = 7;
  localparam int MD_CHG   = 8;
  localparam int MD_EN    = 9;

  // ==========================================================================
  // Profiles
  typedef enum logic [3:0] {
    UCM_OFF, UCM_SDP, UCM_CDP, UCM_SDP_RW, UCM_CDP_RW,
    UCM_DCP_DIV, UCM_DCP_BC, UCM_FORCE_DIV, UCM_FORCE_BC
  } ucm_prof_type;

endpackage

// *** ucm_sel_if.sv ***
// Filtered select and enable carried from the input filter to the mode logic
`timescale 1ns/1ps
`default_nettype none
interface ucm_sel_if;
  logic [2:0] code;
  logic       en;
  logic       chg;
  modport src  (output code, output en, output chg);
  modport sink (input code, input en, input chg);
endinterface
`default_nettype wire

// *** ucm_sel_filter.sv ***
// Synchroniser for the select and enable pins, stability filter for the select code
`timescale 1ns/1ps
`default_nettype none
module ucm_sel_filter #(
  parameter int STABLE = ucm_pkg::STABLE_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic en_pin,
  input  wire logic mode_select_bit1,
  input  wire logic mode_select_bit2,
  input  wire logic mode_select_bit3,
  ucm_sel_if.src    sel
);

  // ==========================================================================
  // Two-stage synchronisers
  logic [3:0] raw;
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  assign raw = {en_pin, mode_select_bit1, mode_select_bit2, mode_select_bit3};

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
        end else begin
          s1_q[g] <= raw[g];
          s2_q[g] <= s1_q[g];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Stability filter: a code counts only after STABLE equal samples
  logic [2:0]  cand_q;
  logic [2:0]  acc_q;
  logic [7:0]  cnt_q;
  logic        chg_q;
  wire         same    = (s2_q[2:0] == cand_q);
  wire         settled = same && (cnt_q == 8'(STABLE - 1));
  wire         accept  = settled && (cand_q != acc_q);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cand_q <= ucm_pkg::CODE_OFF;
      acc_q  <= ucm_pkg::CODE_OFF;
      cnt_q  <= 8'h00;
      chg_q  <= 1'b0;
    end else begin
      cand_q <= s2_q[2:0];
      cnt_q  <= !same ? 8'h00 : (settled ? cnt_q : cnt_q + 8'h01);
      chg_q  <= accept;
      if (accept) begin
        acc_q <= cand_q;
      end
    end
  end

  assign sel.code = acc_q;
  assign sel.en   = s2_q[3];
  assign sel.chg  = chg_q;

  // ==========================================================================
  // Checks
  property p_code_stable;
    @(posedge clk_sys) disable iff (!nrst)
      chg_q |-> $past(cand_q) == acc_q && $past(cnt_q) == 8'(STABLE - 1);
  endproperty
  a_code_stable: assert property (p_code_stable)
    else $error("select code accepted before it was stable");

endmodule
`default_nettype wire

// *** ucm_charge_mode.sv ***
// USB port charge mode selector: profile sequencing, discharge and charging flag
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ucm_charge_mode #(
  parameter int TICK_CYCLES    = ucm_pkg::TICK_CYCLES,
  parameter int DISCH_MS       = ucm_pkg::DISCH_MS,
  parameter int DCP_TIMEOUT_MS = ucm_pkg::DCP_TIMEOUT_MS,
  parameter int CHG_OFF_MS     = ucm_pkg::CHG_OFF_MS,
  parameter int STABLE         = ucm_pkg::STABLE_CYCLES
) (
  input  wire logic                      clk_sys,
  input  wire logic                      nrst,
  input  wire logic                      en_pin,
  input  wire logic                      mode_select_bit1,
  input  wire logic                      mode_select_bit2,
  input  wire logic                      mode_select_bit3,
  input  wire logic                      fs_hs_attach,
  input  wire logic                      dev_detach,
  input  wire logic                      chg_negotiation,
  input  wire logic                      cdp_handshake_done,
  input  wire logic                      iout_above_threshold,
  input  wire logic [ucm_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]               reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [31:0]               reg_rdata,
  output logic                           irq,
  output logic                           power_sw_on,
  output logic                           data_sw_on,
  output logic                           discharge_on,
  output logic                           chg_detect_en,
  output logic                           remote_wakeup_en,
  output logic                           short_dp_dm,
  output logic                           divider_on,
  output logic                           cdp_emul_on,
  output logic      [3:0]                profile,
  output logic                           charging_out,
  output logic                           charging_oe_n
);

  // ==========================================================================
  // Select filter
  ucm_sel_if sel ();

  ucm_sel_filter #(
    .STABLE           (STABLE)
  ) u_filter (
    .clk_sys          (clk_sys),
    .nrst             (nrst),
    .en_pin           (en_pin),
    .mode_select_bit1 (mode_select_bit1),
    .mode_select_bit2 (mode_select_bit2),
    .mode_select_bit3 (mode_select_bit3),
    .sel              (sel)
  );

  // ==========================================================================
  // Status pin synchronisers, plus a third stage for edge detection
  logic [4:0] ev_raw;
  logic [4:0] ev1_q;
  logic [4:0] ev2_q;
  logic [4:0] ev3_q;
  assign ev_raw = {iout_above_threshold, cdp_handshake_done, chg_negotiation,
                   dev_detach, fs_hs_attach};

  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_evsync
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          ev1_q[g] <= 1'b0;
          ev2_q[g] <= 1'b0;
          ev3_q[g] <= 1'b0;
        end else begin
          ev1_q[g] <= ev_raw[g];
          ev2_q[g] <= ev1_q[g];
          ev3_q[g] <= ev2_q[g];
        end
      end
    end
  endgenerate

  wire fs_hs_rise = ev2_q[0] && !ev3_q[0];
  wire detach_rise = ev2_q[1] && !ev3_q[1];
  wire negot_rise = ev2_q[2] && !ev3_q[2];
  wire hs_rise = ev2_q[3] && !ev3_q[3];
  wire iout_hi = ev2_q[4];

  // ==========================================================================
  // Millisecond tick
  localparam int CNT_W_T = 20;
  logic [CNT_W_T-1:0] tick_cnt_q;
  wire tick = (tick_cnt_q == CNT_W_T'(TICK_CYCLES - 1));

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) tick_cnt_q <= '0;
    else tick_cnt_q <= tick ? '0 : tick_cnt_q + CNT_W_T'(1);
  end

  // ==========================================================================
  // Code decode and transition class
  function automatic ucm_pkg::ucm_prof_type decode(input logic [2:0] c);
    unique case (c)
      ucm_pkg::CODE_SDP:       decode = ucm_pkg::UCM_SDP;
      ucm_pkg::CODE_CDP:       decode = ucm_pkg::UCM_CDP;
      ucm_pkg::CODE_SDP_RW:    decode = ucm_pkg::UCM_SDP_RW;
      ucm_pkg::CODE_CDP_RW:    decode = ucm_pkg::UCM_CDP_RW;
      ucm_pkg::CODE_DCP_AUTO:  decode = ucm_pkg::UCM_DCP_DIV;
      ucm_pkg::CODE_FORCE_DIV: decode = ucm_pkg::UCM_FORCE_DIV;
      ucm_pkg::CODE_FORCE_BC:  decode = ucm_pkg::UCM_FORCE_BC;
      ucm_pkg::CODE_OFF:       decode = ucm_pkg::UCM_OFF;
    endcase
  endfunction

  function automatic logic wake_pair(input logic [2:0] a, input logic [2:0] b);
    logic a_s0;
    logic b_s0;
    a_s0 = (a[1:0] == ucm_pkg::CODE_SDP[1:0]) || (a == ucm_pkg::CODE_CDP);
    b_s0 = (b[1:0] == ucm_pkg::CODE_SDP[1:0]) || (b == ucm_pkg::CODE_CDP);
    wake_pair = ((a == ucm_pkg::CODE_SDP) && (b == ucm_pkg::CODE_SDP_RW)) ||
                ((a == ucm_pkg::CODE_SDP_RW) && (b == ucm_pkg::CODE_SDP)) ||
                (a_s0 && (b == ucm_pkg::CODE_CDP_RW)) ||
                ((a == ucm_pkg::CODE_CDP_RW) && b_s0);
  endfunction

  // ==========================================================================
  // Profile sequencer
  ucm_pkg::ucm_prof_type prof_q;
  ucm_pkg::ucm_prof_type prof_d;
  logic [2:0]             applied_q;
  logic                   en_q;
  logic [15:0]            disch_q;
  logic                   dcp_run_q;
  logic [15:0]            dcp_ms_q;
  logic                   disch_start;
  logic                   ev_to_bc;
  logic                   ev_to_div;

  wire en_s       = sel.en;
  wire en_rise    = en_s && !en_q;
  wire code_evt   = en_s && en_q && sel.chg;
  wire is_wake    = wake_pair(applied_q, sel.code);
  wire disch_act  = (disch_q != 16'h0000);
  wire disch_done = (disch_q == 16'h0001) && tick;
  wire dcp_exp    = dcp_run_q && tick && (dcp_ms_q == 16'(DCP_TIMEOUT_MS - 1));

  always_comb begin
    prof_d      = prof_q;
    disch_start = 1'b0;
    ev_to_bc    = 1'b0;
    ev_to_div   = 1'b0;
    if (!en_s) begin
      prof_d = ucm_pkg::UCM_OFF;
    end else if (en_rise || code_evt) begin
      prof_d      = decode(sel.code);
      // Wakeup pairs keep VBUS up so a suspended device can signal resume
      disch_start = (sel.code != ucm_pkg::CODE_OFF) &&
                    (en_rise || !is_wake);
    end else begin
      unique case (prof_q)
        ucm_pkg::UCM_CDP_RW: begin
          if (fs_hs_rise || detach_rise) begin
            prof_d    = ucm_pkg::UCM_DCP_DIV;
            ev_to_div = 1'b1;
          end
        end
        ucm_pkg::UCM_DCP_DIV: begin
          if (negot_rise && !disch_act) begin
            prof_d      = ucm_pkg::UCM_DCP_BC;
            disch_start = 1'b1;
            ev_to_bc    = 1'b1;
          end
        end
        ucm_pkg::UCM_DCP_BC: begin
          if (dcp_exp) begin
            prof_d    = ucm_pkg::UCM_DCP_DIV;
            ev_to_div = 1'b1;
          end
        end
        default: prof_d = prof_q;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      prof_q    <= ucm_pkg::UCM_OFF;
      applied_q <= ucm_pkg::CODE_OFF;
      en_q      <= 1'b0;
    end else begin
      prof_q <= prof_d;
      en_q   <= en_s;
      if (en_rise || code_evt) applied_q <= sel.code;
    end
  end

  // Discharge pulse counts down whole milliseconds; restarts on a new transition
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) disch_q <= 16'h0000;
    else if (!en_s) disch_q <= 16'h0000;
    else if (disch_start) disch_q <= 16'(DISCH_MS);
    else if (disch_act && tick) disch_q <= disch_q - 16'h0001;
  end

  // BC1.2 detach timeout: armed by a detach, dropped by a new negotiation
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dcp_run_q <= 1'b0;
      dcp_ms_q  <= 16'h0000;
    end else if (prof_q != ucm_pkg::UCM_DCP_BC || negot_rise) begin
      dcp_run_q <= 1'b0;
      dcp_ms_q  <= 16'h0000;
    end else if (detach_rise) begin
      dcp_run_q <= 1'b1;
      dcp_ms_q  <= 16'h0000;
    end else if (dcp_run_q && tick) begin
      dcp_ms_q <= dcp_ms_q + 16'h0001;
    end
  end

  // ==========================================================================
  // Charging flag
  wire cdp_mode  = (prof_q == ucm_pkg::UCM_CDP) || (prof_q == ucm_pkg::UCM_CDP_RW);
  wire chg_modes = cdp_mode || (prof_q == ucm_pkg::UCM_DCP_DIV) ||
                   (prof_q == ucm_pkg::UCM_DCP_BC) ||
                   (prof_q == ucm_pkg::UCM_FORCE_DIV) ||
                   (prof_q == ucm_pkg::UCM_FORCE_BC);
  wire chg_allow = en_s && chg_modes && !disch_act;
  logic        hs_ok_q;
  logic        chg_q;
  logic [15:0] off_ms_q;
  wire chg_set   = chg_allow && iout_hi && (!cdp_mode || hs_ok_q);
  wire off_exp   = tick && (off_ms_q == 16'(CHG_OFF_MS - 1));
  wire chg_clr   = chg_q && (!chg_allow || (!iout_hi && off_exp));

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hs_ok_q  <= 1'b0;
      chg_q    <= 1'b0;
      off_ms_q <= 16'h0000;
    end else begin
      // Handshake only counts if it came while the load was still light
      if (!cdp_mode || detach_rise) hs_ok_q <= 1'b0;
      else if (hs_rise && !iout_hi) hs_ok_q <= 1'b1;
      if (chg_clr) chg_q <= 1'b0;
      else if (chg_set) chg_q <= 1'b1;
      if (iout_hi || !chg_q) off_ms_q <= 16'h0000;
      else if (tick && !off_exp) off_ms_q <= off_ms_q + 16'h0001;
    end
  end

  // ==========================================================================
  // Registers and interrupt
  logic [ucm_pkg::STAT_W-1:0] stat_q;
  logic [ucm_pkg::STAT_W-1:0] mask_q;
  logic [ucm_pkg::STAT_W-1:0] ev_vec;
  logic [31:0]                mode_word;
  logic [31:0]                rd_mux;
  wire rd_stat = reg_rd && (reg_addr == ucm_pkg::ADDR_STAT);
  wire wr_mask = reg_wr && (reg_addr == ucm_pkg::ADDR_MASK);

  assign ev_vec = {chg_clr, chg_set && !chg_q, ev_to_div, ev_to_bc, disch_done, code_evt};
  assign mode_word = {22'h0, en_s, chg_q, disch_act, applied_q, prof_q};
  assign rd_mux = (reg_addr == ucm_pkg::ADDR_STAT) ? {26'h0, stat_q} :
                  (reg_addr == ucm_pkg::ADDR_MASK) ? {26'h0, mask_q} :
                  (reg_addr == ucm_pkg::ADDR_MODE) ? mode_word : 32'h0;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stat_q    <= '0;
      mask_q    <= ucm_pkg::MASK_RST;
      reg_rdata <= 32'h0;
      irq       <= 1'b0;
    end else begin
      // A new event in the clearing read cycle survives
      stat_q    <= (rd_stat ? '0 : stat_q) | ev_vec;
      if (wr_mask) mask_q <= reg_wdata[ucm_pkg::STAT_W-1:0];
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
      irq       <= |(stat_q & mask_q);
    end
  end

  // ==========================================================================
  // Registered pin outputs, one cycle behind the profile
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      power_sw_on      <= 1'b0;
      data_sw_on       <= 1'b0;
      discharge_on     <= 1'b1;
      chg_detect_en    <= 1'b0;
      remote_wakeup_en <= 1'b0;
      short_dp_dm      <= 1'b0;
      divider_on       <= 1'b0;
      cdp_emul_on      <= 1'b0;
      profile          <= 4'h0;
      charging_out     <= 1'b0;
      charging_oe_n    <= 1'b1;
    end else begin
      power_sw_on      <= (prof_q != ucm_pkg::UCM_OFF) && !disch_act;
      data_sw_on       <= (prof_q inside {ucm_pkg::UCM_SDP, ucm_pkg::UCM_CDP,
                           ucm_pkg::UCM_SDP_RW, ucm_pkg::UCM_CDP_RW}) && !disch_act;
      discharge_on     <= (prof_q == ucm_pkg::UCM_OFF) || disch_act;
      chg_detect_en    <= chg_modes;
      remote_wakeup_en <= (prof_q == ucm_pkg::UCM_SDP_RW) || (prof_q == ucm_pkg::UCM_CDP_RW);
      short_dp_dm      <= (prof_q == ucm_pkg::UCM_DCP_BC) || (prof_q == ucm_pkg::UCM_FORCE_BC);
      divider_on       <= (prof_q == ucm_pkg::UCM_DCP_DIV) || (prof_q == ucm_pkg::UCM_FORCE_DIV);
      cdp_emul_on      <= cdp_mode;
      profile          <= prof_q;
      charging_out     <= 1'b0;
      charging_oe_n    <= !chg_q;
    end
  end

  // ==========================================================================
  // Checks
  property p_disabled_off;
    @(posedge clk_sys) disable iff (!nrst)
      !en_s |-> ##2 (discharge_on && !power_sw_on && !data_sw_on && charging_oe_n);
  endproperty
  a_disabled_off: assert property (p_disabled_off)
    else $error("outputs not off two cycles after enable low");

  property p_code_off;
    @(posedge clk_sys) disable iff (!nrst)
      (code_evt && sel.code == ucm_pkg::CODE_OFF) |=> prof_q == ucm_pkg::UCM_OFF ##1 discharge_on;
  endproperty
  a_code_off: assert property (p_code_off)
    else $error("code 000 did not switch the port off");

  property p_decode_cdp;
    @(posedge clk_sys) disable iff (!nrst)
      (code_evt && sel.code == ucm_pkg::CODE_CDP) |=> prof_q == ucm_pkg::UCM_CDP;
  endproperty
  a_decode_cdp: assert property (p_decode_cdp)
    else $error("code 111 did not select CDP");

  property p_wake_no_pulse;
    @(posedge clk_sys) disable iff (!nrst)
      (code_evt && is_wake && !disch_act) |=> !disch_act [*3];
  endproperty
  a_wake_no_pulse: assert property (p_wake_no_pulse)
    else $error("discharge pulse on a remote wakeup transition");

  property p_pulse_len;
    @(posedge clk_sys) disable iff (!nrst)
      (code_evt && !is_wake && sel.code != ucm_pkg::CODE_OFF) |=> disch_q == 16'(DISCH_MS);
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("discharge pulse not loaded with its full length");

  property p_auto_leave;
    @(posedge clk_sys) disable iff (!nrst)
      (en_s && en_q && !sel.chg && prof_q == ucm_pkg::UCM_CDP_RW && detach_rise)
        |=> prof_q == ucm_pkg::UCM_DCP_DIV;
  endproperty
  a_auto_leave: assert property (p_auto_leave)
    else $error("CDP wakeup mode did not move to divider after detach");

  property p_negot;
    @(posedge clk_sys) disable iff (!nrst)
      (en_s && en_q && !sel.chg && prof_q == ucm_pkg::UCM_DCP_DIV && negot_rise && !disch_act)
        |=> (prof_q == ucm_pkg::UCM_DCP_BC && disch_act) ##1 !power_sw_on;
  endproperty
  a_negot: assert property (p_negot)
    else $error("negotiation did not give discharge then BC1.2");

  property p_cdp_hs;
    @(posedge clk_sys) disable iff (!nrst)
      (!chg_q && cdp_mode && !hs_ok_q) |=> !chg_q;
  endproperty
  a_cdp_hs: assert property (p_cdp_hs)
    else $error("charging flag in CDP without prior handshake");

  property p_hold_flag;
    @(posedge clk_sys) disable iff (!nrst)
      (chg_q && chg_allow && $past(iout_hi)) |-> chg_q ##1 (chg_q || !chg_allow || tick);
  endproperty
  a_hold_flag: assert property (p_hold_flag)
    else $error("charging flag dropped without the off deglitch");

endmodule
`default_nettype wire

// *** ucm_host_model.sv ***
// Host controller model that drives the mode select and enable pins
`timescale 1ns/1ps
`default_nettype none
module ucm_host_model (
  input  wire logic       clk_sys,
  input  wire logic [2:0] code_req,
  input  wire logic       en_req,
  output logic            mode_select_bit1,
  output logic            mode_select_bit2,
  output logic            mode_select_bit3,
  output logic            en_pin
);
  initial begin
    {mode_select_bit1, mode_select_bit2, mode_select_bit3, en_pin} = 4'h0;
  end
  // ==========================================================================
  // Pins
  // All bits move on one edge, so no transient code appears between codes
  always @(posedge clk_sys) begin
    {mode_select_bit1, mode_select_bit2, mode_select_bit3} <= code_req;
    en_pin <= en_req;
  end
endmodule
`default_nettype wire

// *** usb_charge_mode_selector_tb.sv ***
// Self-checking bench for the charge mode selector
`timescale 1ns/1ps
`default_nettype none
module usb_charge_mode_selector_tb;
  logic        clk_sys, nrst, en_req, att, det, neg, hsk, iout, wr, rd;
  logic        b1, b2, b3, en_pin, irq, pw, dsw, dis, cde, rwe, oe_n;
  logic        sdm, dvo, cem, cho;
  logic [2:0]  code_req;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  prof;
  int          miscompares = 0;
  int          checks = 0;
  int          n;

  ucm_host_model host (.clk_sys(clk_sys), .code_req(code_req), .en_req(en_req),
    .mode_select_bit1(b1), .mode_select_bit2(b2), .mode_select_bit3(b3), .en_pin(en_pin));

  // Short counts: tick 10 cycles, pulse 50, auto timeout 80, flag release 60
  ucm_charge_mode #(.TICK_CYCLES(10), .DISCH_MS(5), .DCP_TIMEOUT_MS(8), .CHG_OFF_MS(6),
    .STABLE(4)) dut (.clk_sys(clk_sys), .nrst(nrst), .en_pin(en_pin),
    .mode_select_bit1(b1), .mode_select_bit2(b2), .mode_select_bit3(b3),
    .fs_hs_attach(att), .dev_detach(det), .chg_negotiation(neg),
    .cdp_handshake_done(hsk), .iout_above_threshold(iout), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .irq(irq),
    .power_sw_on(pw), .data_sw_on(dsw), .discharge_on(dis), .chg_detect_en(cde),
    .remote_wakeup_en(rwe), .short_dp_dm(sdm), .divider_on(dvo), .cdp_emul_on(cem),
    .profile(prof), .charging_out(cho), .charging_oe_n(oe_n));

  // ==========================================================================
  // Tasks
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  // Counts cycles with the output discharge on
  task automatic watch(input int k);
    n = 0;
    repeat (k) begin
      @(posedge clk_sys);
      #1 n += int'(dis === 1'b1);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic evt(ref logic s);
    @(posedge clk_sys);
    s <= 1'b1;
    repeat (4) @(posedge clk_sys);
    s <= 1'b0;
  endtask
  task automatic apply(input logic [2:0] c, input logic p, input logic [3:0] pr);
    @(posedge clk_sys);
    code_req <= c;
    watch(75);
    chk("pulse", p, n > 0);
    chk("profile", pr, prof);
  endtask
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================================
  // Stimulus
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (6000) @(posedge clk_sys);
    miscompares++;
    wrap_up;
  end
  initial begin
    {nrst, en_req, att, det, neg, hsk, iout, wr, rd} = 9'h000;
    code_req = 3'h0;
    addr = 8'h00;
    wdata = 32'h0;
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    wr_reg(8'h04, 32'h10);
    @(posedge clk_sys);
    en_req <= 1'b1;
    cyc(20);
    chk("discharge", 1, dis);
    chk("profile", 0, prof);
    apply(3'h6, 1, 1);
    chk("data switch", 1, dsw);
    apply(3'h2, 0, 3);
    chk("wakeup", 1, rwe);
    apply(3'h3, 0, 4);
    chk("cdp emulation", 1, cem);
    apply(3'h7, 0, 2);
    chk("detect", 1, cde);
    iout <= 1'b1;
    cyc(10);
    chk("flag", 1, oe_n);
    iout <= 1'b0;
    evt(hsk);
    iout <= 1'b1;
    cyc(10);
    chk("flag", 0, oe_n);
    chk("flag data", 0, cho);
    chk("irq", 1, irq);
    rd_reg(8'h00);
    chk("status", 32'h10, d & 32'h10);
    rd_reg(8'h00);
    chk("status", 0, d);
    cyc(3);
    chk("irq", 0, irq);
    iout <= 1'b0;
    cyc(30);
    chk("flag", 0, oe_n);
    cyc(50);
    chk("flag", 1, oe_n);
    apply(3'h3, 0, 4);
    evt(att);
    cyc(10);
    chk("profile", 5, prof);
    apply(3'h1, 1, 5);
    chk("divider", 1, dvo);
    evt(neg);
    watch(80);
    chk("pulse", 1, n > 0);
    chk("profile", 6, prof);
    chk("short", 1, sdm);
    evt(det);
    cyc(50);
    chk("profile", 6, prof);
    cyc(50);
    chk("profile", 5, prof);
    apply(3'h5, 1, 7);
    apply(3'h4, 1, 8);
    apply(3'h0, 1, 0);
    apply(3'h6, 1, 1);
    rd_reg(8'h08);
    chk("mode", 32'h261, d);
    @(posedge clk_sys);
    en_req <= 1'b0;
    cyc(10);
    chk("discharge", 1, dis);
    chk("data switch", 0, dsw);
    chk("flag", 1, oe_n);
    apply(3'h7, 1, 0);
    rd_reg(8'h10);
    chk("unmapped", 0, d);
    wrap_up;
  end
endmodule
`default_nettype wire
